// file: design/pct_defs.svh
// Register map, field layout, reset values and sizes of the countdown timer
`ifndef PCT_DEFS_SVH
`define PCT_DEFS_SVH

`define PCT_OFS_PRESET_LOW 8'h0a
`define PCT_OFS_PRESET_HIGH 8'h0b
`define PCT_OFS_COUNT_LOW 8'h0c
`define PCT_OFS_COUNT_HIGH_SHADOW 8'h0d

`define PCT_RST_PRESET_LOW 8'h00
`define PCT_RST_PRESET_HIGH 4'h0
`define PCT_RST_COUNT 12'h000
`define PCT_RST_SHADOW 4'h0

`define PCT_LOW_MSB 7
`define PCT_HIGH_LSB 8
`define PCT_HIGH_NIBBLE_MSB 3
`define PCT_COUNT_WIDTH 12

`define PCT_I2C_DEV_ADDR 7'h52
`define PCT_I2C_BITS 4'h8

`endif

// file: design/pct_pkg.sv
// Types of the countdown timer's serial register port
package pct_pkg;

    // Serial port states, one-hot
    typedef enum logic [6:0] {
        PCT_IDLE = 7'h01,
        PCT_ADDR = 7'h02,
        PCT_ACK_ADDR = 7'h04,
        PCT_WDATA = 7'h08,
        PCT_ACK_W = 7'h10,
        PCT_RDATA = 7'h20,
        PCT_ACK_R = 7'h40
    } pct_state_type;

endpackage

// file: design/pct_reg_if.sv
// Register access strobes between the serial port and the timer core
`timescale 1ns/1ps
interface pct_reg_if;
    logic wr_stb;
    logic rd_stb;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;

    modport port_side (output wr_stb, output rd_stb, output addr, output wdata, input rdata);
    modport core_side (input wr_stb, input rd_stb, input addr, input wdata, output rdata);
endinterface

// file: design/pct_i2c_slave.sv
// I2C target: pointer byte, auto-incrementing register writes and reads
`timescale 1ns/1ps
`include "pct_defs.svh"
module pct_i2c_slave #(
    parameter logic [6:0] DEV_ADDR = `PCT_I2C_DEV_ADDR
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    pct_reg_if.port_side bus
);
    logic scl_s1_q, scl_s2_q, scl_s3_q;
    logic sda_s1_q, sda_s2_q, sda_s3_q;
    logic scl_rise, scl_fall, start_seen, stop_seen;
    pct_pkg::pct_state_type state_q;
    logic [3:0] bit_cnt_q;
    logic [7:0] shift_q;
    logic [7:0] ptr_q;
    logic rw_q, first_q, nack_q, oe_q;
    logic wr_stb_q, rd_stb_q;
    logic [7:0] wdata_q;

    // Two-stage synchronisers, third stage for edges
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            {scl_s1_q, scl_s2_q, scl_s3_q} <= 3'h7;
            {sda_s1_q, sda_s2_q, sda_s3_q} <= 3'h7;
        end
        else
        begin
            {scl_s1_q, scl_s2_q, scl_s3_q} <= {scl_in, scl_s1_q, scl_s2_q};
            {sda_s1_q, sda_s2_q, sda_s3_q} <= {sda_in, sda_s1_q, sda_s2_q};
        end
    end

    assign scl_rise = scl_s2_q && !scl_s3_q;
    assign scl_fall = !scl_s2_q && scl_s3_q;
    assign start_seen = scl_s2_q && scl_s3_q && !sda_s2_q && sda_s3_q;
    assign stop_seen = scl_s2_q && scl_s3_q && sda_s2_q && !sda_s3_q;

    // Frame sequencing, bit shifting and register strobes
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_q <= pct_pkg::PCT_IDLE;
            bit_cnt_q <= 4'h0;
            shift_q <= 8'h00;
            ptr_q <= 8'h00;
            rw_q <= 1'b0;
            first_q <= 1'b0;
            nack_q <= 1'b0;
            oe_q <= 1'b0;
            wr_stb_q <= 1'b0;
            rd_stb_q <= 1'b0;
            wdata_q <= 8'h00;
        end
        else
        begin
            wr_stb_q <= 1'b0;
            rd_stb_q <= 1'b0;
            if (start_seen)
            begin
                state_q <= pct_pkg::PCT_ADDR;
                bit_cnt_q <= 4'h0;
                first_q <= 1'b1;
                oe_q <= 1'b0;
            end
            else if (stop_seen)
            begin
                state_q <= pct_pkg::PCT_IDLE;
                oe_q <= 1'b0;
            end
            else
            begin
                unique case (state_q)
                    pct_pkg::PCT_IDLE:
                    begin
                        oe_q <= 1'b0;
                    end
                    pct_pkg::PCT_ADDR, pct_pkg::PCT_WDATA:
                    begin
                        if (scl_rise && bit_cnt_q != `PCT_I2C_BITS)
                        begin
                            shift_q <= {shift_q[6:0], sda_s2_q};
                            bit_cnt_q <= bit_cnt_q + 4'h1;
                        end
                        else if (scl_fall && bit_cnt_q == `PCT_I2C_BITS)
                        begin
                            if (state_q == pct_pkg::PCT_ADDR)
                            begin
                                if (shift_q[7:1] == DEV_ADDR)
                                begin
                                    rw_q <= shift_q[0];
                                    oe_q <= 1'b1;
                                    state_q <= pct_pkg::PCT_ACK_ADDR;
                                end
                                else
                                begin
                                    state_q <= pct_pkg::PCT_IDLE;
                                end
                            end
                            else
                            begin
                                oe_q <= 1'b1;
                                state_q <= pct_pkg::PCT_ACK_W;
                                first_q <= 1'b0;
                                if (first_q)
                                begin
                                    ptr_q <= shift_q;
                                end
                                else
                                begin
                                    wr_stb_q <= 1'b1;
                                    wdata_q <= shift_q;
                                end
                            end
                        end
                    end
                    pct_pkg::PCT_ACK_ADDR, pct_pkg::PCT_ACK_W:
                    begin
                        if (wr_stb_q)
                        begin
                            ptr_q <= ptr_q + 8'h01;
                        end
                        if (scl_fall)
                        begin
                            bit_cnt_q <= 4'h0;
                            if (state_q == pct_pkg::PCT_ACK_ADDR && rw_q)
                            begin
                                shift_q <= bus.rdata;
                                oe_q <= !bus.rdata[7];
                                rd_stb_q <= 1'b1;
                                state_q <= pct_pkg::PCT_RDATA;
                            end
                            else
                            begin
                                oe_q <= 1'b0;
                                state_q <= pct_pkg::PCT_WDATA;
                            end
                        end
                    end
                    pct_pkg::PCT_RDATA:
                    begin
                        if (rd_stb_q)
                        begin
                            ptr_q <= ptr_q + 8'h01;
                        end
                        if (scl_fall)
                        begin
                            if (bit_cnt_q == `PCT_I2C_BITS - 4'h1)
                            begin
                                oe_q <= 1'b0;
                                state_q <= pct_pkg::PCT_ACK_R;
                            end
                            else
                            begin
                                shift_q <= {shift_q[6:0], 1'b0};
                                oe_q <= !shift_q[6];
                                bit_cnt_q <= bit_cnt_q + 4'h1;
                            end
                        end
                    end
                    pct_pkg::PCT_ACK_R:
                    begin
                        if (scl_rise)
                        begin
                            nack_q <= sda_s2_q;
                        end
                        else if (scl_fall)
                        begin
                            bit_cnt_q <= 4'h0;
                            if (nack_q)
                            begin
                                state_q <= pct_pkg::PCT_IDLE;
                            end
                            else
                            begin
                                shift_q <= bus.rdata;
                                oe_q <= !bus.rdata[7];
                                rd_stb_q <= 1'b1;
                                state_q <= pct_pkg::PCT_RDATA;
                            end
                        end
                    end
                    default:
                    begin
                        state_q <= pct_pkg::PCT_IDLE;
                    end
                endcase
            end
        end
    end

    // Open-drain drive: only ever pulls low
    assign sda_out = 1'b0;
    assign sda_oe = oe_q;
    assign bus.wr_stb = wr_stb_q;
    assign bus.rd_stb = rd_stb_q;
    assign bus.addr = ptr_q;
    assign bus.wdata = wdata_q;
endmodule // pct_i2c_slave

// file: design/pct_timer.sv
// Periodic countdown timer core with its preset and count registers
`timescale 1ns/1ps
`include "pct_defs.svh"
module pct_timer #(
    parameter int COUNT_W = `PCT_COUNT_WIDTH,
    parameter logic [6:0] DEV_ADDR = `PCT_I2C_DEV_ADDR
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic write_lock,
    input wire logic countdown_run_enable,
    input wire logic countdown_repeat_select,
    input wire logic timer_tick,
    output logic timer_event
);
    pct_reg_if rif ();
    logic [7:0] preset_low_q;
    logic [3:0] preset_high_q;
    logic [11:0] count_q;
    logic [11:0] status_q;
    logic [3:0] shadow_q;
    logic run_prev_q;
    logic event_q;
    logic [11:0] preset;

    // Layout checks at elaboration
    if (COUNT_W != 12)
    begin : g_bad_width
        $error("pct_timer supports only a 12-bit counter");
    end

    pct_i2c_slave #(
        .DEV_ADDR(DEV_ADDR)
    ) u_port (
        .clk(clk),
        .nrst(nrst),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .sda_out(sda_out),
        .sda_oe(sda_oe),
        .bus(rif.port_side)
    );

    assign preset = {preset_high_q, preset_low_q};

    // Preset registers, writable only when unlocked
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            preset_low_q <= `PCT_RST_PRESET_LOW;
            preset_high_q <= `PCT_RST_PRESET_HIGH;
        end
        else if (rif.wr_stb && !write_lock)
        begin
            if (rif.addr == `PCT_OFS_PRESET_LOW)
            begin
                preset_low_q <= rif.wdata;
            end
            if (rif.addr == `PCT_OFS_PRESET_HIGH)
            begin
                preset_high_q <= rif.wdata[`PCT_HIGH_NIBBLE_MSB:0];
            end
        end
    end

    // Countdown with automatic reload and expiry event
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            count_q <= `PCT_RST_COUNT;
            run_prev_q <= 1'b0;
            event_q <= 1'b0;
        end
        else
        begin
            run_prev_q <= countdown_run_enable;
            event_q <= 1'b0;
            if (countdown_run_enable && !run_prev_q)
            begin
                count_q <= preset;
            end
            else if (countdown_run_enable && timer_tick)
            begin
                if (count_q > 12'h001)
                begin
                    count_q <= count_q - 12'h001;
                end
                else if (count_q == 12'h001)
                begin
                    event_q <= 1'b1;
                    count_q <= countdown_repeat_select ? preset : 12'h000;
                end
                else if (countdown_repeat_select)
                begin
                    count_q <= preset;
                end
            end
        end
    end

    // Status copy follows counter only while running
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            status_q <= `PCT_RST_COUNT;
        end
        else if (countdown_run_enable)
        begin
            status_q <= count_q;
        end
    end

    // Upper count shadow, latched by low count read
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            shadow_q <= `PCT_RST_SHADOW;
        end
        else if (rif.rd_stb && rif.addr == `PCT_OFS_COUNT_LOW)
        begin
            shadow_q <= status_q[11:`PCT_HIGH_LSB];
        end
    end

    // Read multiplexer; count registers have no write path
    always_comb
    begin
        unique case (rif.addr)
            `PCT_OFS_PRESET_LOW: rif.rdata = preset_low_q;
            `PCT_OFS_PRESET_HIGH: rif.rdata = {4'h0, preset_high_q};
            `PCT_OFS_COUNT_LOW: rif.rdata = status_q[`PCT_LOW_MSB:0];
            `PCT_OFS_COUNT_HIGH_SHADOW: rif.rdata = {4'h0, shadow_q};
            default: rif.rdata = 8'h00;
        endcase
    end

    assign timer_event = event_q;

    chk_preset_low_write: assert property (@(posedge clk) disable iff (!nrst)
        rif.wr_stb && !write_lock && rif.addr == `PCT_OFS_PRESET_LOW |=> preset_low_q == $past(rif.wdata))
        else $error("low preset not written");
    chk_preset_high_write: assert property (@(posedge clk) disable iff (!nrst)
        rif.wr_stb && !write_lock && rif.addr == `PCT_OFS_PRESET_HIGH |=> preset_high_q == $past(rif.wdata[3:0]))
        else $error("high preset not written");
    chk_lock_blocks_write: assert property (@(posedge clk) disable iff (!nrst)
        rif.wr_stb && write_lock |=> $stable(preset))
        else $error("locked preset changed");
    chk_reload_on_expiry: assert property (@(posedge clk) disable iff (!nrst)
        countdown_run_enable && run_prev_q && timer_tick && countdown_repeat_select && count_q == 12'h001
        |=> count_q == $past(preset) && timer_event)
        else $error("no reload at expiry");
    chk_oneshot_stops: assert property (@(posedge clk) disable iff (!nrst)
        run_prev_q && countdown_run_enable && !countdown_repeat_select && count_q == 12'h000 |=> count_q == 12'h000)
        else $error("one-shot counter moved past zero");
    chk_event_cause: assert property (@(posedge clk) disable iff (!nrst)
        timer_event |-> $past(count_q) == 12'h001 && $past(timer_tick) && $past(countdown_run_enable))
        else $error("event without expiry");
    chk_decrement_step: assert property (@(posedge clk) disable iff (!nrst)
        countdown_run_enable && run_prev_q && timer_tick && count_q > 12'h001 |=> count_q == $past(count_q) - 12'h001)
        else $error("counter did not decrement");
    chk_status_frozen: assert property (@(posedge clk) disable iff (!nrst)
        !countdown_run_enable |=> $stable(status_q))
        else $error("status moved while stopped");
    chk_shadow_latch: assert property (@(posedge clk) disable iff (!nrst)
        rif.rd_stb && rif.addr == `PCT_OFS_COUNT_LOW |=> shadow_q == $past(status_q[11:8]) ##1 $stable(shadow_q))
        else $error("shadow not latched");
    chk_status_write_ignored: assert property (@(posedge clk) disable iff (!nrst)
        rif.wr_stb && rif.addr == `PCT_OFS_COUNT_HIGH_SHADOW |=> $stable(shadow_q))
        else $error("write changed shadow");

    cov_periodic_event: cover property (@(posedge clk) disable iff (!nrst)
        timer_event && countdown_repeat_select ##[1:1000] timer_event);
    cov_locked_write: cover property (@(posedge clk) disable iff (!nrst) rif.wr_stb && write_lock);
    cov_shadow_read: cover property (@(posedge clk) disable iff (!nrst)
        rif.rd_stb && rif.addr == `PCT_OFS_COUNT_LOW ##[1:1000] rif.rd_stb && rif.addr == `PCT_OFS_COUNT_HIGH_SHADOW);
endmodule // pct_timer

// file: tb/pct_host_model.sv
// Host model: I2C master reaching the timer registers
`timescale 1ns/1ps
`include "pct_defs.svh"
module pct_host_model (
    input wire logic clk,
    input wire logic sda_line,
    output logic scl,
    output logic sda_low
);
    int nacks;

    // Idle bus with both lines released
    initial
    begin
        scl = 1'b1;
        sda_low = 1'b0;
        nacks = 0;
    end

    // Wait n clocks, then step just past the edge
    task automatic hold(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Start or repeated start: data falls while clock is high
    task automatic start();
        sda_low = 1'b0;
        hold(4);
        scl = 1'b1;
        hold(8);
        sda_low = 1'b1;
        hold(8);
        scl = 1'b0;
        hold(4);
    endtask

    // Stop: data rises while clock is high
    task automatic stop();
        sda_low = 1'b1;
        hold(8);
        scl = 1'b1;
        hold(8);
        sda_low = 1'b0;
        hold(8);
    endtask

    // Bit out, data changed only while clock is low
    task automatic put_bit(input logic b);
        sda_low = ~b;
        hold(8);
        scl = 1'b1;
        hold(8);
        scl = 1'b0;
        hold(4);
    endtask

    // Bit in, sampled mid high phase
    task automatic get_bit(output logic b);
        sda_low = 1'b0;
        hold(8);
        scl = 1'b1;
        hold(4);
        b = sda_line;
        hold(4);
        scl = 1'b0;
        hold(4);
    endtask

    // Byte out MSB first, then the target's acknowledge
    task automatic put_byte(input logic [7:0] d, output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--)
        begin
            put_bit(d[i]);
        end
        get_bit(b);
        ack = ~b;
    endtask

    // Byte in MSB first, then our acknowledge or refusal
    task automatic get_byte(input logic more, output logic [7:0] d);
        for (int i = 7; i >= 0; i--)
        begin
            get_bit(d[i]);
        end
        put_bit(~more);
    endtask

    // Start plus address byte
    task automatic address(input logic [6:0] dev, input logic rd, output logic ack);
        start();
        put_byte({dev, rd}, ack);
    endtask

    // One register write through the pointer byte
    task automatic write_reg(input logic [7:0] ptr, input logic [7:0] d);
        logic a0, a1, a2;
        address(`PCT_I2C_DEV_ADDR, 1'b0, a0);
        put_byte(ptr, a1);
        put_byte(d, a2);
        stop();
        if ({a0, a1, a2} !== 3'b111)
            nacks++;
    endtask

    // One or two bytes; the low count byte goes first for a coherent pair
    task automatic read_reg(input logic [7:0] ptr, input logic two, output logic [7:0] d0,
        output logic [7:0] d1);
        logic a0, a1, a2;
        d1 = 8'h00;
        address(`PCT_I2C_DEV_ADDR, 1'b0, a0);
        put_byte(ptr, a1);
        address(`PCT_I2C_DEV_ADDR, 1'b1, a2);
        get_byte(two, d0);
        if (two)
            get_byte(1'b0, d1);
        stop();
        if ({a0, a1, a2} !== 3'b111)
            nacks++;
    endtask
endmodule // pct_host_model

// file: tb/test_periodic_countdown_timer.sv
// Self-checking bench of the periodic countdown timer
`timescale 1ns/1ps
`include "pct_defs.svh"
module test_periodic_countdown_timer;
    logic clk, nrst, write_lock, run_en, rpt_sel, timer_tick, tick_req;
    logic sda_out, sda_oe, timer_event, scl, host_low;
    wire sda_line;
    int errors = 0, checks_done = 0, events_seen = 0;

    // Open-drain data line with pull-up
    assign sda_line = ~((sda_oe & ~sda_out) | host_low);

    pct_timer dut_u (.clk(clk), .nrst(nrst), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
        .sda_oe(sda_oe), .write_lock(write_lock), .countdown_run_enable(run_en),
        .countdown_repeat_select(rpt_sel), .timer_tick(timer_tick), .timer_event(timer_event));
    pct_host_model host_u (.clk(clk), .sda_line(sda_line), .scl(scl), .sda_low(host_low));

    // 250 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // Count cycles with the event pulse high
    always @(posedge clk)
    begin
        if (timer_event === 1'b1)
            events_seen++;
    end

    // Tick shaper: a held request gives a one-cycle tick every other cycle, launched just after the edge
    always @(posedge clk)
        timer_tick <= #1 (tick_req && !timer_tick);

    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks_done++;
        if (got !== exp)
        begin
            errors++;
            $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic expect_reg(input logic [7:0] ptr, input logic [7:0] exp);
        logic [7:0] d0, d1;
        host_u.read_reg(ptr, 1'b0, d0, d1);
        check(d0, exp, "register read");
    endtask

    // Burst read of the count pair from the low byte
    task automatic expect_count(input logic [7:0] lo, input logic [7:0] hi);
        logic [7:0] d0, d1;
        host_u.read_reg(`PCT_OFS_COUNT_LOW, 1'b1, d0, d1);
        check(d0, lo, "count low");
        check(d1, hi, "count high");
    endtask

    // Timer clock ticks, one cycle each with gaps
    task automatic pulse_tick(input int n);
        repeat (n)
        begin
            tick_req = 1'b1;
            host_u.hold(1);
            tick_req = 1'b0;
            host_u.hold(3);
        end
    endtask

    task automatic t_reset();
        expect_reg(`PCT_OFS_PRESET_LOW, 8'h00);
        expect_reg(`PCT_OFS_PRESET_HIGH, 8'h00);
        expect_count(8'h00, 8'h00);
        expect_reg(8'h20, 8'h00);
    endtask

    task automatic t_preset();
        host_u.write_reg(`PCT_OFS_PRESET_LOW, 8'ha5);
        host_u.write_reg(`PCT_OFS_PRESET_HIGH, 8'hff);
        expect_reg(`PCT_OFS_PRESET_LOW, 8'ha5);
        expect_reg(`PCT_OFS_PRESET_HIGH, 8'h0f);
        expect_count(8'h00, 8'h00);
    endtask

    task automatic t_lock();
        write_lock = 1'b1;
        host_u.write_reg(`PCT_OFS_PRESET_LOW, 8'h3c);
        host_u.write_reg(`PCT_OFS_PRESET_HIGH, 8'h07);
        expect_reg(`PCT_OFS_PRESET_LOW, 8'ha5);
        expect_reg(`PCT_OFS_PRESET_HIGH, 8'h0f);
        write_lock = 1'b0;
    endtask

    task automatic t_readonly();
        host_u.write_reg(`PCT_OFS_COUNT_LOW, 8'hff);
        host_u.write_reg(`PCT_OFS_COUNT_HIGH_SHADOW, 8'hff);
        expect_count(8'h00, 8'h00);
    endtask

    // Live count, shadow latching, freeze on disable
    task automatic t_count();
        host_u.write_reg(`PCT_OFS_PRESET_LOW, 8'h03);
        host_u.write_reg(`PCT_OFS_PRESET_HIGH, 8'h01);
        run_en = 1'b1;
        host_u.hold(4);
        expect_count(8'h03, 8'h01);
        pulse_tick(3);
        expect_count(8'h00, 8'h01);
        pulse_tick(1);
        expect_reg(`PCT_OFS_COUNT_HIGH_SHADOW, 8'h01);
        expect_reg(`PCT_OFS_COUNT_LOW, 8'hff);
        expect_reg(`PCT_OFS_COUNT_HIGH_SHADOW, 8'h00);
        run_en = 1'b0;
        pulse_tick(2);
        expect_count(8'hff, 8'h00);
    endtask

    // One-shot expiry, then periodic reloads
    task automatic t_periodic();
        int e0;
        host_u.write_reg(`PCT_OFS_PRESET_HIGH, 8'h00);
        host_u.write_reg(`PCT_OFS_PRESET_LOW, 8'h03);
        e0 = events_seen;
        run_en = 1'b1;
        host_u.hold(4);
        pulse_tick(2);
        check(8'(events_seen - e0), 8'h00, "early event");
        pulse_tick(1);
        check(8'(events_seen - e0), 8'h01, "one-shot event");
        pulse_tick(2);
        expect_count(8'h00, 8'h00);
        check(8'(events_seen - e0), 8'h01, "event after stop");
        rpt_sel = 1'b1;
        pulse_tick(1);
        expect_count(8'h03, 8'h00);
        pulse_tick(9);
        check(8'(events_seen - e0), 8'h04, "periodic events");
        expect_count(8'h03, 8'h00);
    endtask

    // Foreign address is refused, own address still served
    task automatic t_address();
        logic ack;
        host_u.address(~`PCT_I2C_DEV_ADDR, 1'b0, ack);
        host_u.stop();
        check({7'h00, ack}, 8'h00, "foreign address ack");
        expect_reg(`PCT_OFS_PRESET_LOW, 8'h03);
        check(8'(host_u.nacks), 8'h00, "refused transfers");
    endtask

    task automatic give_verdict();
        if (errors == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        nrst = 1'b0;
        write_lock = 1'b0;
        run_en = 1'b0;
        rpt_sel = 1'b0;
        tick_req = 1'b0;
        host_u.hold(5);
        nrst = 1'b1;
        host_u.hold(4);
        t_reset();
        t_preset();
        t_lock();
        t_readonly();
        t_count();
        t_periodic();
        t_address();
        give_verdict();
    end

    // Watchdog against a hung transfer
    initial
    begin
        #300us;
        errors++;
        $display("BAD %0t watchdog expired", $time);
        give_verdict();
    end
endmodule // test_periodic_countdown_timer
